// >>> hdl/tap_host.sv
// Boundary-scan controller that drives the link from the core clock
`timescale 1ns/1ps
module tap_host
    import tap_pkg::*;
#(
    parameter int MAX_LEN = 64,
    parameter int LEN_W   = 7,
    parameter int DIV     = 10
)
(
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               rstn_in,
    // Link
    tap_if.host                     link,
    // Scan requests
    input  wire logic               cmd_valid_in,
    input  wire logic [1:0]         cmd_op_in,
    input  wire logic [LEN_W-1:0]   cmd_len_in,
    input  wire logic [MAX_LEN-1:0] cmd_data_in,
    output logic                    cmd_ready_out,
    // Scan results
    output logic                    rsp_valid_out,
    output logic [MAX_LEN-1:0]      rsp_data_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    // DIV must stay at or above TCK_MIN_DIV; the data-out sample point sits
    // one core cycle before the rising edge, which needs DIV of 6 or more
    localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
    localparam logic [7:0] HALF_C   = 8'(DIV / 2);
    localparam logic [7:0] SAMPLE_C = 8'(DIV / 2 - 1);

    typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_SHIFT, PH_POST} phase_e;

    phase_e             phase_reg,  phase_next;
    logic [7:0]         div_reg,    div_next;
    logic               tck_reg,    tck_next;
    logic               tms_reg,    tms_next;
    logic               tdi_reg,    tdi_next;
    logic [5:0]         seq_reg,    seq_next;
    logic [2:0]         scnt_reg,   scnt_next;
    logic [1:0]         op_reg,     op_next;
    logic [LEN_W-1:0]   len_reg,    len_next;
    logic [LEN_W-1:0]   cnt_reg,    cnt_next;
    logic [MAX_LEN-1:0] tx_reg,     tx_next;
    logic [MAX_LEN-1:0] rx_reg,     rx_next;
    logic               shift_reg,  shift_next;
    logic               ready_reg,  ready_next;
    logic               rsp_v_reg,  rsp_v_next;
    logic [MAX_LEN-1:0] rsp_d_reg,  rsp_d_next;
    logic               tdo_s1_reg;
    logic               tdo_s2_reg;

    assign link.tck      = tck_reg;
    assign link.tms      = tms_reg;
    assign link.tdi      = tdi_reg;
    assign cmd_ready_out = ready_reg;
    assign rsp_valid_out = rsp_v_reg;
    assign rsp_data_out  = rsp_d_reg;

    // ************************************************************
    // Sequencer: new bits at the falling edge, data-out just before rise
    // ************************************************************
    always_comb
    begin
        phase_next = phase_reg;
        seq_next   = seq_reg;
        scnt_next  = scnt_reg;
        op_next    = op_reg;
        len_next   = len_reg;
        cnt_next   = cnt_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        tms_next   = tms_reg;
        tdi_next   = tdi_reg;
        shift_next = shift_reg;
        rsp_v_next = 1'b0;
        rsp_d_next = rsp_d_reg;
        div_next   = (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
        tck_next   = (div_next >= HALF_C);
        if ((div_reg == SAMPLE_C) && shift_reg)
            rx_next = {tdo_s2_reg, rx_reg[MAX_LEN-1:1]};
        if (div_reg == DIV_LAST)
        begin
            unique case (phase_reg)
                PH_IDLE:
                    if (cmd_valid_in && ready_reg)
                    begin
                        op_next  = cmd_op_in;
                        len_next = cmd_len_in;
                        tx_next  = cmd_data_in;
                        rx_next  = '0;
                        if (cmd_op_in == OP_RESET)
                        begin
                            seq_next  = SEQ_RESET >> 1;
                            scnt_next = LEN_RESET - 3'h1;
                            tms_next  = SEQ_RESET[0];
                        end
                        else if (cmd_op_in == OP_IR)
                        begin
                            seq_next  = SEQ_IR >> 1;
                            scnt_next = LEN_IR - 3'h1;
                            tms_next  = SEQ_IR[0];
                        end
                        else
                        begin
                            seq_next  = SEQ_DR >> 1;
                            scnt_next = LEN_DR - 3'h1;
                            tms_next  = SEQ_DR[0];
                        end
                        phase_next = PH_PRE;
                    end
                PH_PRE, PH_POST:
                    if (scnt_reg != 3'h0)
                    begin
                        tms_next  = seq_reg[0];
                        seq_next  = seq_reg >> 1;
                        scnt_next = scnt_reg - 3'h1;
                    end
                    else if ((phase_reg == PH_PRE) && (op_reg != OP_RESET))
                    begin
                        tms_next   = (len_reg == LEN_W'(1));
                        tdi_next   = tx_reg[0];
                        tx_next    = tx_reg >> 1;
                        cnt_next   = len_reg - LEN_W'(1);
                        shift_next = 1'b1;
                        phase_next = PH_SHIFT;
                    end
                    else
                    begin
                        rsp_v_next = 1'b1;
                        rsp_d_next = rx_reg >> (MAX_LEN - int'(len_reg));
                        phase_next = PH_IDLE;
                    end
                PH_SHIFT:
                    if (cnt_reg != '0)
                    begin
                        tms_next = (cnt_reg == LEN_W'(1));
                        tdi_next = tx_reg[0];
                        tx_next  = tx_reg >> 1;
                        cnt_next = cnt_reg - LEN_W'(1);
                    end
                    else
                    begin
                        tms_next   = 1'b1;
                        tdi_next   = 1'b0;
                        seq_next   = 6'h00;
                        scnt_next  = LEN_POST - 3'h1;
                        shift_next = 1'b0;
                        phase_next = PH_POST;
                    end
            endcase
        end
        ready_next = (phase_next == PH_IDLE) && (div_next == DIV_LAST);
    end

    // Data-out comes from another clock's flops, so two stages first
    always_ff @(posedge core_clk_in)
    begin
        tdo_s1_reg <= link.tdo_line;
        tdo_s2_reg <= tdo_s1_reg;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            phase_reg <= PH_IDLE;
            div_reg   <= 8'h00;
            tck_reg   <= 1'b0;
            tms_reg   <= 1'b1;
            tdi_reg   <= 1'b0;
            seq_reg   <= 6'h00;
            scnt_reg  <= 3'h0;
            op_reg    <= OP_RESET;
            len_reg   <= '0;
            cnt_reg   <= '0;
            tx_reg    <= '0;
            rx_reg    <= '0;
            shift_reg <= 1'b0;
            ready_reg <= 1'b0;
            rsp_v_reg <= 1'b0;
            rsp_d_reg <= '0;
        end
        else
        begin
            phase_reg <= phase_next;
            div_reg   <= div_next;
            tck_reg   <= tck_next;
            tms_reg   <= tms_next;
            tdi_reg   <= tdi_next;
            seq_reg   <= seq_next;
            scnt_reg  <= scnt_next;
            op_reg    <= op_next;
            len_reg   <= len_next;
            cnt_reg   <= cnt_next;
            tx_reg    <= tx_next;
            rx_reg    <= rx_next;
            shift_reg <= shift_next;
            ready_reg <= ready_next;
            rsp_v_reg <= rsp_v_next;
            rsp_d_reg <= rsp_d_next;
        end
    end

endmodule

// >>> shared/tap_pkg.sv
// Shared constants and types for the boundary-scan link and its two ends
package tap_pkg;

    // ************************************************************
    // Register widths and instruction codes
    // ************************************************************
    localparam int         IR_W           = 3;
    localparam int         ID_W           = 32;
    localparam logic [2:0] INS_EXTEST     = 3'h0;
    localparam logic [2:0] INS_IDCODE     = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ    = 3'h2;
    localparam logic [2:0] INS_PRELOAD    = 3'h4;
    localparam logic [2:0] INS_BYPASS     = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    localparam logic       IR_CAPTURE_TOP = 1'h0;

    // ************************************************************
    // Identification word: revision, part, maker, marker bit
    // ************************************************************
    localparam logic [2:0] ID_REV  = 3'h0;
    localparam logic       ID_MARK = 1'h1;

    // ************************************************************
    // Port state machine
    // ************************************************************
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_e;

    // ************************************************************
    // Controller requests and mode-select sequences (first bit in bit 0)
    // ************************************************************
    localparam logic [1:0] OP_RESET  = 2'h0;
    localparam logic [1:0] OP_IR     = 2'h1;
    localparam logic [1:0] OP_DR     = 2'h2;
    localparam logic [5:0] SEQ_RESET = 6'h1f;
    localparam logic [2:0] LEN_RESET = 3'h6;
    localparam logic [5:0] SEQ_IR    = 6'h03;
    localparam logic [2:0] LEN_IR    = 3'h4;
    localparam logic [5:0] SEQ_DR    = 6'h01;
    localparam logic [2:0] LEN_DR    = 3'h3;
    localparam logic [2:0] LEN_POST  = 3'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int TCK_MIN_PERIOD_NS = 50;
    localparam int CORE_PERIOD_NS    = 8;
    localparam int TCK_MIN_DIV       =
        (TCK_MIN_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

endpackage

// >>> shared/tap_if.sv
// Serial test link between the controller and the device
`timescale 1ns/1ps
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_en_n;
    logic tdo_line;

    // Undriven data-out reads high, as a pulled-up wire would
    assign tdo_line = tdo_en_n ? 1'b1 : tdo;

    modport dev  (input tck, input tms, input tdi, output tdo, output tdo_en_n);
    modport host (output tck, output tms, output tdi, input tdo_line);
endinterface

// >>> hdl/tap_device.sv
// Boundary-scan test port of the memory, clocked by the link clock
`timescale 1ns/1ps
module tap_device
    import tap_pkg::*;
#(
    parameter int          PIN_CELLS = 32,
    parameter int          NC_CELLS  = 4,
    parameter logic [16:0] DEVICE_ID = 17'h0a5a5, // Arbitrary value
    parameter logic [10:0] VENDOR_ID = 11'h2b3,   // Arbitrary value
    localparam int         BSR_LEN   = PIN_CELLS + NC_CELLS
)
(
    // Power-up reset, sampled on the link clock
    input  wire logic                 rstn_in,
    // Link
    tap_if.dev                        link,
    // Memory pin ring
    input  wire logic [PIN_CELLS-1:0] ring_in,
    output logic                      hiz_out,
    output logic [BSR_LEN-1:0]        preload_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, DEVICE_ID, VENDOR_ID, ID_MARK};

    logic [PIN_CELLS-1:0] ring_s1_reg;
    logic [PIN_CELLS-1:0] ring_s2_reg;
    logic                 rstn_s1_reg;
    logic                 rstn_s2_reg;
    tap_state_e           state_reg;
    tap_state_e           state_next;
    logic [IR_W-1:0]      ir_reg;
    logic [IR_W-1:0]      ir_next;
    logic [ID_W-1:0]      id_reg;
    logic [ID_W-1:0]      id_next;
    logic                 byp_reg;
    logic                 byp_next;
    logic [BSR_LEN-1:0]   bsr_reg;
    logic [BSR_LEN-1:0]   bsr_next;
    logic [IR_W-1:0]      instr_reg;
    logic [IR_W-1:0]      instr_next;
    logic                 tdo_reg;
    logic                 tdo_next;
    logic                 tdo_en_n_reg;
    logic                 tdo_en_n_next;
    logic                 hiz_reg;
    logic                 hiz_next;
    logic [BSR_LEN-1:0]   latch_reg;
    logic [BSR_LEN-1:0]   latch_next;
    logic                 sel_id;
    logic                 sel_bsr;
    logic                 dr_lsb;

    assign link.tdo     = tdo_reg;
    assign link.tdo_en_n = tdo_en_n_reg;
    assign hiz_out      = hiz_reg;
    assign preload_out  = latch_reg;

    // ************************************************************
    // Register selection from the active instruction
    // ************************************************************
    // Reserved codes fall back to bypass so a stray code never breaks the chain
    always_comb
    begin
        sel_id  = (instr_reg == INS_IDCODE);
        sel_bsr = (instr_reg == INS_EXTEST) || (instr_reg == INS_SAMPLEZ) ||
                  (instr_reg == INS_PRELOAD);
        if (sel_id)
            dr_lsb = id_reg[0];
        else if (sel_bsr)
            dr_lsb = bsr_reg[0];
        else
            dr_lsb = byp_reg;
    end

    // ************************************************************
    // Port state machine
    // ************************************************************
    always_comb
    begin
        unique case (state_reg)
            ST_RESET:    state_next = link.tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_next = link.tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_next = link.tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_next = link.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = link.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = link.tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = link.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = link.tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_next = link.tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_next = link.tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_next = link.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = link.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = link.tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = link.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = link.tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_next = link.tms ? ST_SEL_DR   : ST_IDLE;
        endcase
    end

    // ************************************************************
    // Scan registers, rising edge
    // ************************************************************
    always_comb
    begin
        ir_next  = ir_reg;
        id_next  = id_reg;
        byp_next = byp_reg;
        bsr_next = bsr_reg;
        if (state_reg == ST_RESET)
            ir_next = INS_IDCODE;
        if (state_reg == ST_CAP_IR)
            ir_next = {IR_CAPTURE_TOP, IR_CAPTURE_LOW};
        if (state_reg == ST_SHIFT_IR)
            ir_next = {link.tdi, ir_reg[IR_W-1:1]};
        if (state_reg == ST_CAP_DR)
        begin
            if (sel_id)
                id_next = ID_VALUE;
            else if (sel_bsr)
                bsr_next = {{NC_CELLS{1'b0}}, ring_s2_reg};
            else
                byp_next = 1'b0;
        end
        if (state_reg == ST_SHIFT_DR)
        begin
            if (sel_id)
                id_next = {link.tdi, id_reg[ID_W-1:1]};
            else if (sel_bsr)
                bsr_next = {link.tdi, bsr_reg[BSR_LEN-1:1]};
            else
                byp_next = link.tdi;
        end
    end

    // Pin ring is asynchronous to the link clock, so it is synchronised
    // first; a pin toggling during capture still yields an uncertain bit
    // Power-up reset comes from another clock, so it passes two stages too
    always_ff @(posedge link.tck)
    begin
        ring_s1_reg <= ring_in;
        ring_s2_reg <= ring_s1_reg;
        rstn_s1_reg <= rstn_in;
        rstn_s2_reg <= rstn_s1_reg;
    end

    always_ff @(posedge link.tck)
    begin
        if (!rstn_s2_reg)
        begin
            state_reg <= ST_RESET;
            ir_reg    <= INS_IDCODE;
            id_reg    <= '0;
            byp_reg   <= 1'b0;
            bsr_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            ir_reg    <= ir_next;
            id_reg    <= id_next;
            byp_reg   <= byp_next;
            bsr_reg   <= bsr_next;
        end
    end

    // ************************************************************
    // Active instruction and outputs, falling edge
    // ************************************************************
    always_comb
    begin
        instr_next = instr_reg;
        latch_next = latch_reg;
        tdo_next   = tdo_reg;
        if (state_reg == ST_RESET)
            instr_next = INS_IDCODE;
        else if (state_reg == ST_UPD_IR)
            instr_next = ir_reg;
        if ((state_reg == ST_UPD_DR) && sel_bsr)
            latch_next = bsr_reg;
        if (state_reg == ST_SHIFT_IR)
            tdo_next = ir_reg[0];
        else if (state_reg == ST_SHIFT_DR)
            tdo_next = dr_lsb;
        tdo_en_n_next = !((state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR));
        hiz_next = (instr_next == INS_EXTEST) || (instr_next == INS_SAMPLEZ);
    end

    always_ff @(negedge link.tck)
    begin
        if (!rstn_s2_reg)
        begin
            instr_reg    <= INS_IDCODE;
            tdo_reg      <= 1'b0;
            tdo_en_n_reg <= 1'b1;
            hiz_reg      <= 1'b0;
            latch_reg    <= '0;
        end
        else
        begin
            instr_reg    <= instr_next;
            tdo_reg      <= tdo_next;
            tdo_en_n_reg <= tdo_en_n_next;
            hiz_reg      <= hiz_next;
            latch_reg    <= latch_next;
        end
    end

endmodule

// >>> dv/sram_boundary_scan_tap_props.sv
// Checker on the serial test link
`timescale 1ns/1ps
module sram_boundary_scan_tap_props
(
    // Link and test port reset
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_en_n,
    input wire logic rstn_in
);
    logic [1:0] rise_reg;

    // Snapshot at the rise; link outputs may only move at the fall
    always_ff @(posedge tck)
        rise_reg <= {tdo, tdo_en_n};

    default clocking cb @(posedge tck); endclocking
    default disable iff (!rstn_in);

    // ********
    // Properties
    // ********
    sequence s_ones5; tms [*5]; endsequence
    sequence s_quiet4; tdo_en_n [*4]; endsequence
    property p_fall_only;
        @(negedge tck) disable iff (!rstn_in) {tdo, tdo_en_n} == rise_reg;
    endproperty
    property p_high_idle; $past(tms) |-> tdo_en_n; endproperty
    property p_ones_reset; s_ones5 |=> s_quiet4; endproperty
    property p_wake_quiet; $rose(rstn_in) |-> s_quiet4; endproperty
    property p_shift_hold; !tdo_en_n && !tms |=> !tdo_en_n; endproperty
    // Shift is entered from capture or from the second exit; both paths
    // leave exactly one high select among the two steps before the last
    property p_enter_zeros; $fell(tdo_en_n) |-> !$past(tms); endproperty
    property p_enter_sel; $fell(tdo_en_n) |-> $past(tms, 2) != $past(tms, 3); endproperty
    property p_exit_gap; $rose(tdo_en_n) |-> tdo_en_n [*3]; endproperty

    // ********
    // Assertions
    // ********
    a_fall_only: assert property (p_fall_only)
        else $error("link output moved at rise");
    a_high_idle: assert property (p_high_idle)
        else $error("driving after high select");
    a_ones_reset: assert property (p_ones_reset)
        else $error("no reset after five highs");
    a_wake_quiet: assert property (p_wake_quiet)
        else $error("driving right after reset");
    a_shift_hold: assert property (p_shift_hold)
        else $error("shift left with select low");
    a_enter_zeros: assert property (p_enter_zeros)
        else $error("bad path into shift");
    a_enter_sel: assert property (p_enter_sel)
        else $error("shift without select step");
    a_exit_gap: assert property (p_exit_gap)
        else $error("shift re-entered too soon");
endmodule

// >>> dv/sram_boundary_scan_tap_test.sv
// Testbench: controller and test port joined over the serial link
`timescale 1ns/1ps
module sram_boundary_scan_tap_test;
    import tap_pkg::*;
    localparam int              BSR = 36;
    localparam logic [16:0]     DEV = 17'h1c3e7; // Arbitrary value
    localparam logic [10:0]     VEN = 11'h35a;   // Arbitrary value
    localparam logic [ID_W-1:0] IDW = {ID_REV, DEV, VEN, ID_MARK};
    logic           clk      = 1'b0;
    logic           rstn     = 1'b0;
    logic           dev_rstn = 1'b0;
    logic           valid    = 1'b0;
    logic [1:0]     op       = 2'h0;
    logic [6:0]     len      = 7'h0;
    logic [63:0]    din      = 64'h0;
    logic [31:0]    ring     = 32'h0;
    logic           ready;
    logic           rsp_v;
    logic           hiz;
    logic [63:0]    rsp;
    logic [BSR-1:0] pre;
    logic [63:0]    res;
    int             ir_m = 1;
    int             err_count = 0;
    int             samples_checked = 0;

    tap_if link ();
    tap_host tap_host_inst (.core_clk_in(clk), .rstn_in(rstn), .link(link),
        .cmd_valid_in(valid), .cmd_op_in(op), .cmd_len_in(len), .cmd_data_in(din),
        .cmd_ready_out(ready), .rsp_valid_out(rsp_v), .rsp_data_out(rsp));
    tap_device #(.DEVICE_ID(DEV), .VENDOR_ID(VEN)) tap_device_inst (.rstn_in(dev_rstn),
        .link(link), .ring_in(ring), .hiz_out(hiz), .preload_out(pre));
    sram_boundary_scan_tap_props props_inst (.tck(link.tck), .tms(link.tms),
        .tdo(link.tdo), .tdo_en_n(link.tdo_en_n), .rstn_in(dev_rstn));

    initial forever #4 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request, held until taken; the wait is bounded in core cycles
    task automatic scan(input logic [1:0] o, input int n, input logic [63:0] d);
        int w;
        w = 0;
        {valid, op, len, din} = {1'b1, o, n[6:0], d};
        while (ready !== 1'b1 && w < 500)
        begin
            @(posedge clk);
            #1 w++;
        end
        @(posedge clk);
        #1 valid = 1'b0;
        while (rsp_v !== 1'b1 && w < 2000)
        begin
            @(posedge clk);
            #1 w++;
        end
        if (w >= 2000)
            err_count++;
        res = rsp;
    endtask

    // Reference chain: captured bits leave first, new bits join at the top
    function automatic logic [63:0] model(input int n, input logic [63:0] d);
        bit          q[$];
        int          c;
        logic [63:0] o;
        o = 64'h0;
        c = (ir_m == 1) ? ID_W : (ir_m inside {0, 2, 4}) ? BSR : 1;
        for (int i = 0; i < c; i++)
            q.push_back(c == ID_W ? IDW[i] : (c == BSR && i < 32) ? ring[i] : 1'b0);
        for (int i = 0; i < n; i++)
        begin
            o[i] = q.pop_front();
            q.push_back(d[i]);
        end
        return o;
    endfunction

    task automatic ir(input int code);
        scan(OP_IR, IR_W, 64'(code));
        check(res, {61'h0, IR_CAPTURE_TOP, IR_CAPTURE_LOW});
        ir_m = code;
    endtask

    task automatic dr(input int n);
        logic [63:0] d;
        logic [63:0] e;
        d = {$urandom, $urandom};
        e = model(n, d);
        scan(OP_DR, n, d);
        check(res, e);
        if (n == BSR && ir_m inside {0, 2, 4})
            check(64'(pre), 64'(d[BSR-1:0]));
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h3106ae97));
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (30) @(posedge clk);
        #1 dev_rstn = 1'b1;
        check(64'({hiz, pre}), 64'h0);
        scan(OP_RESET, 1, 64'h0);
        dr(ID_W);
        $display("test power_up done");
        ir(INS_BYPASS);
        for (int n = 1; n <= 64; n += 21)
            dr(n);
        $display("test bypass done");
        for (int k = 0; k < 3; k++)
        begin
            ring = $urandom;
            ir(k * 2);
            check(64'(hiz), 64'(k < 2));
            dr(BSR);
        end
        ir(INS_IDCODE);
        check(64'(hiz), 64'h0);
        dr(ID_W);
        $display("test sample_modes done");
        ir(INS_SAMPLEZ);
        scan(OP_RESET, 1, 64'h0);
        ir_m = 1;
        check(64'(hiz), 64'h0);
        dr(ID_W);
        $display("test reset_run done");
        close_out();
    end

    // Whole run needs about 5k core cycles; this leaves ample margin
    initial
    begin
        #400000;
        err_count++;
        close_out();
    end
endmodule
